// >>> verilog/tsm_pkg.sv
// Package: register map, field positions, modes and event carriers of the slave-mode timer
package tsm_pkg;

  // ====================================
  // Register offsets
  localparam logic [7:0]  TSM_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  TSM_OFS_SLAVE   = 8'h08;
  localparam logic [7:0]  TSM_OFS_ENABLE  = 8'h0C;
  localparam logic [7:0]  TSM_OFS_FLAGS   = 8'h10;
  localparam logic [7:0]  TSM_OFS_COUNT   = 8'h24;

  // ====================================
  // Field positions
  localparam int          TSM_CEN_BIT     = 0;
  localparam int          TSM_MODE_LSB    = 0;
  localparam int          TSM_SRC_LSB     = 4;
  localparam int          TSM_ECE_BIT     = 14;
  localparam int          TSM_UPDIRQ_BIT  = 0;
  localparam int          TSM_CCIE_LSB    = 1;
  localparam int          TSM_TRGIRQ_BIT  = 6;
  localparam int          TSM_UPDDMA_BIT  = 8;
  localparam int          TSM_CCDE_LSB    = 9;
  localparam int          TSM_PSDE_BIT    = 13;
  localparam int          TSM_TRGDMA_BIT  = 14;
  localparam int          TSM_UF_BIT      = 0;
  localparam int          TSM_CCF_LSB     = 1;
  localparam int          TSM_PSF_BIT     = 5;
  localparam int          TSM_TF_BIT      = 6;

  // ====================================
  // Writable-bit masks and reset values
  localparam logic [15:0] TSM_ENABLE_MASK = 16'h7F5F;
  localparam logic [15:0] TSM_FLAGS_MASK  = 16'h007F;
  localparam logic [15:0] TSM_ENABLE_RST  = 16'h0000;
  localparam logic [15:0] TSM_FLAGS_RST   = 16'h0000;
  localparam logic [15:0] TSM_COUNT_RST   = 16'h0000;
  localparam logic [15:0] TSM_COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TSM_COUNT_ONE   = 16'h0001;

  // ====================================
  // Slave modes
  typedef enum logic [2:0] {
    TSM_INTERNAL = 3'b000,
    TSM_ENC1     = 3'b001,
    TSM_ENC2     = 3'b010,
    TSM_ENC3     = 3'b011,
    TSM_RESET    = 3'b100,
    TSM_GATED    = 3'b101,
    TSM_TRIGGER  = 3'b110,
    TSM_EXTCLK   = 3'b111
  } tsm_mode_e;

  // ====================================
  // Carriers
  typedef struct packed {
    logic       trig;
    logic       phase;
    logic [3:0] cc;
    logic       upd;
  } tsm_events_s;

  typedef struct packed {
    logic       ece;
    logic [2:0] src;
    tsm_mode_e  mode;
  } tsm_slave_s;

  localparam tsm_slave_s TSM_SLAVE_RST = '{ece: 1'b0, src: 3'h0, mode: TSM_INTERNAL};

endpackage : tsm_pkg

// >>> verilog/tsm_trig_det.sv
// Trigger source selector with registered level and edge detection
module tsm_trig_det (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] src_in,
  input  wire logic [3:0] itr_in,
  input  wire logic       ti1_edge_in,
  input  wire logic       ti1_in,
  input  wire logic       ti2_in,
  input  wire logic       xtrg_in,
  output logic            level_out,
  output logic            rise_out,
  output logic            edge_out
);

  // ====================================
  // Source mux
  logic sel;

  // Source is only changed while the slave mode is idle, so no glitch guard
  always_comb begin
    case (src_in)
      3'h0:    sel = itr_in[0];
      3'h1:    sel = itr_in[1];
      3'h2:    sel = itr_in[2];
      3'h3:    sel = itr_in[3];
      3'h4:    sel = ti1_edge_in;
      3'h5:    sel = ti1_in;
      3'h6:    sel = ti2_in;
      default: sel = xtrg_in;
    endcase
  end

  // ====================================
  // Registered level and edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_out <= 1'b0;
      rise_out  <= 1'b0;
      edge_out  <= 1'b0;
    end else begin
      level_out <= sel;
      rise_out  <= sel & ~level_out;
      edge_out  <= sel ^ level_out;
    end
  end

endmodule : tsm_trig_det

// >>> verilog/tsm_slave_timer.sv
// Slave-mode counter control with DMA and interrupt enable register
// Notes on behaviour
// - Mode 000: counter ticks from the internal clock, or from external trigger rising edges in external clock mode 2; reset default.
// - Mode 001: count on input-two edges, direction from input-one level.
// - Mode 010: count on input-one edges, direction from input-two level.
// - Mode 011: count on both inputs' edges, direction from the other level.
// - Mode 100: trigger rising edge clears counter and raises an update event.
// - Mode 101: counter ticks only while trigger is high.
// - Mode 110: trigger rising edge starts counter; never stops it.
// - Mode 111: each trigger rising edge advances the counter.
// - Trigger DMA request only while enable bit 14 set; resets zero.
// - Phase-switch DMA request only while enable bit 13 set.
// - Channel DMA enables at bits 9 to 12, one per channel.
// - Update DMA request only while enable bit 8 set.
// - Trigger interrupt only while enable bit 6 set.
// - Channel interrupt enables at bits 1 to 4, one per channel.
// - Update interrupt only while enable bit 0 set.
// - With both external clock modes on, count from filtered external trigger.
// - Trigger event: rising trigger edge, or any edge in gating mode.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
module tsm_slave_timer (
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  input  wire logic [7:0]        addr_in,
  input  wire logic [15:0]       wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic              filt_in1_in,
  input  wire logic              filt_in2_in,
  input  wire logic              ti1_edge_in,
  input  wire logic [3:0]        itr_in,
  input  wire logic              xtrg_in,
  input  wire logic [3:0]        cc_event_in,
  input  wire logic              phase_event_in,
  output logic [15:0]            rdata_out,
  output tsm_pkg::tsm_events_s   dma_req_out,
  output logic                   irq_out,
  output logic [15:0]            count_out,
  output logic                   update_event_out
);

  // ====================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  // Two-stage release so deassertion is clean against mclk_in
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ====================================
  // Register state
  tsm_pkg::tsm_slave_s slave_cfg;
  logic [15:0]         enable_reg;
  logic [15:0]         flags;
  logic                counter_enable;
  logic [15:0]         count;

  logic wr_ctrl;
  logic wr_slave;
  logic wr_enable;
  logic wr_flags;
  logic wr_count;

  assign wr_ctrl   = wr_in && (addr_in == tsm_pkg::TSM_OFS_CTRL);
  assign wr_slave  = wr_in && (addr_in == tsm_pkg::TSM_OFS_SLAVE);
  assign wr_enable = wr_in && (addr_in == tsm_pkg::TSM_OFS_ENABLE);
  assign wr_flags  = wr_in && (addr_in == tsm_pkg::TSM_OFS_FLAGS);
  assign wr_count  = wr_in && (addr_in == tsm_pkg::TSM_OFS_COUNT);

  // Enable-bit aliases
  logic       trigger_dma_enable;
  logic       phase_switch_dma_enable;
  logic [3:0] channel_dma_enable;
  logic       update_dma_enable;
  logic       trigger_irq_enable;
  logic [3:0] channel_irq_enable;
  logic       update_irq_enable;

  assign trigger_dma_enable      = enable_reg[tsm_pkg::TSM_TRGDMA_BIT];
  assign phase_switch_dma_enable = enable_reg[tsm_pkg::TSM_PSDE_BIT];
  assign channel_dma_enable      = enable_reg[tsm_pkg::TSM_CCDE_LSB +: 4];
  assign update_dma_enable       = enable_reg[tsm_pkg::TSM_UPDDMA_BIT];
  assign trigger_irq_enable      = enable_reg[tsm_pkg::TSM_TRGIRQ_BIT];
  assign channel_irq_enable      = enable_reg[tsm_pkg::TSM_CCIE_LSB +: 4];
  assign update_irq_enable       = enable_reg[tsm_pkg::TSM_UPDIRQ_BIT];

  // Slave configuration; all modes start at internal clock
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      slave_cfg <= tsm_pkg::TSM_SLAVE_RST;
    end else if (wr_slave) begin
      slave_cfg.mode <= tsm_pkg::tsm_mode_e'(wdata_in[tsm_pkg::TSM_MODE_LSB +: 3]);
      slave_cfg.src  <= wdata_in[tsm_pkg::TSM_SRC_LSB +: 3];
      slave_cfg.ece  <= wdata_in[tsm_pkg::TSM_ECE_BIT];
    end
  end

  // Enable register; masked so reserved bits never hold a one
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= tsm_pkg::TSM_ENABLE_RST;
    end else if (wr_enable) begin
      enable_reg <= wdata_in & tsm_pkg::TSM_ENABLE_MASK;
    end
  end

  // ====================================
  // Trigger input
  logic trig_level;
  logic trig_rise;
  logic trig_edge;

  // Source choice is only safe to change while the mode is idle
  tsm_trig_det u_trig (
    .clk_in      (mclk_in),
    .rst_n_in    (rst_n),
    .src_in      (slave_cfg.src),
    .itr_in      (itr_in),
    .ti1_edge_in (ti1_edge_in),
    .ti1_in      (filt_in1_in),
    .ti2_in      (filt_in2_in),
    .xtrg_in     (xtrg_in),
    .level_out   (trig_level),
    .rise_out    (trig_rise),
    .edge_out    (trig_edge)
  );

  // ====================================
  // Encoder and external clock edges
  logic ti1_q;
  logic ti2_q;
  logic xtrg_q;
  logic ti1_edge;
  logic ti2_edge;
  logic xtrg_rise;

  // Previous input levels
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ti1_q  <= 1'b0;
      ti2_q  <= 1'b0;
      xtrg_q <= 1'b0;
    end else begin
      ti1_q  <= filt_in1_in;
      ti2_q  <= filt_in2_in;
      xtrg_q <= xtrg_in;
    end
  end

  assign ti1_edge  = filt_in1_in ^ ti1_q;
  assign ti2_edge  = filt_in2_in ^ ti2_q;
  assign xtrg_rise = xtrg_in & ~xtrg_q;

  // ====================================
  // Counting clock and direction per slave mode
  logic tick;
  logic count_down;
  logic base_tick;

  // External clock mode 2 replaces the internal clock as the base
  assign base_tick = slave_cfg.ece ? xtrg_rise : 1'b1;

  always_comb begin
    tick       = 1'b0;
    count_down = 1'b0;
    case (slave_cfg.mode)
      // Reset and trigger modes count like mode 000 between their triggers
      tsm_pkg::TSM_INTERNAL, tsm_pkg::TSM_RESET, tsm_pkg::TSM_TRIGGER: begin
        tick = base_tick;
      end
      tsm_pkg::TSM_ENC1: begin
        tick       = ti2_edge;
        count_down = filt_in2_in != filt_in1_in;
      end
      tsm_pkg::TSM_ENC2: begin
        tick       = ti1_edge;
        count_down = filt_in1_in == filt_in2_in;
      end
      tsm_pkg::TSM_ENC3: begin
        // A double edge in one cycle is a lost step and is dropped
        tick       = ti1_edge ^ ti2_edge;
        count_down = ti1_edge ? (filt_in1_in == filt_in2_in)
                              : (filt_in2_in != filt_in1_in);
      end
      tsm_pkg::TSM_GATED: begin
        tick = base_tick & trig_level;
      end
      tsm_pkg::TSM_EXTCLK: begin
        tick = slave_cfg.ece ? xtrg_rise : trig_rise;
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  // ====================================
  // Events of this cycle
  logic                 reset_hit;
  logic                 start_hit;
  logic                 step;
  logic                 wrap;
  tsm_pkg::tsm_events_s events;

  assign reset_hit = trig_rise && (slave_cfg.mode == tsm_pkg::TSM_RESET);
  assign start_hit = trig_rise && (slave_cfg.mode == tsm_pkg::TSM_TRIGGER);
  assign step      = counter_enable && tick;
  assign wrap      = step && (count_down ? (count == 16'h0000)
                                         : (count == tsm_pkg::TSM_COUNT_MAX));

  // Gating reports both edges, every other mode only the rising one
  assign events.trig  = (slave_cfg.mode == tsm_pkg::TSM_GATED) ? trig_edge
                                                               : trig_rise;
  assign events.phase = phase_event_in;
  assign events.cc    = cc_event_in;
  assign events.upd   = wrap || reset_hit;

  // ====================================
  // Counter enable and core counter
  // Hardware start wins over a software clear in the same cycle
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      counter_enable <= 1'b0;
    end else if (start_hit) begin
      counter_enable <= 1'b1;
    end else if (wr_ctrl) begin
      counter_enable <= wdata_in[tsm_pkg::TSM_CEN_BIT];
    end
  end

  // Reset-mode trigger outranks a software load and a count step
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      count <= tsm_pkg::TSM_COUNT_RST;
    end else if (reset_hit) begin
      count <= tsm_pkg::TSM_COUNT_RST;
    end else if (wr_count) begin
      count <= wdata_in;
    end else if (step) begin
      count <= count_down ? count - tsm_pkg::TSM_COUNT_ONE
                          : count + tsm_pkg::TSM_COUNT_ONE;
    end
  end

  // ====================================
  // Sticky flags, cleared by writing zero; a new event wins
  logic [15:0] flag_set;
  logic [15:0] next_flags;

  always_comb begin
    flag_set                                  = 16'h0000;
    flag_set[tsm_pkg::TSM_UF_BIT]             = events.upd;
    flag_set[tsm_pkg::TSM_CCF_LSB +: 4]       = events.cc;
    flag_set[tsm_pkg::TSM_PSF_BIT]            = events.phase;
    flag_set[tsm_pkg::TSM_TF_BIT]             = events.trig;
    next_flags = wr_flags ? (flags & wdata_in) : flags;
    next_flags = (next_flags | flag_set) & tsm_pkg::TSM_FLAGS_MASK;
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      flags <= tsm_pkg::TSM_FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // ====================================
  // DMA requests: one-cycle pulses gated by their enables
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      dma_req_out <= '0;
    end else begin
      dma_req_out.trig  <= events.trig && trigger_dma_enable;
      dma_req_out.phase <= events.phase && phase_switch_dma_enable;
      dma_req_out.cc    <= events.cc & channel_dma_enable;
      dma_req_out.upd   <= events.upd && update_dma_enable;
    end
  end

  // ====================================
  // Interrupt level; phase-switch has no interrupt enable of its own
  logic irq_any;

  assign irq_any = (flags[tsm_pkg::TSM_TF_BIT] && trigger_irq_enable)
                || |(flags[tsm_pkg::TSM_CCF_LSB +: 4] & channel_irq_enable)
                || (flags[tsm_pkg::TSM_UF_BIT] && update_irq_enable);

  // Registered, so it trails the flag by one cycle
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_any;
    end
  end

  // ====================================
  // Mirrors of internal state
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      count_out        <= tsm_pkg::TSM_COUNT_RST;
      update_event_out <= 1'b0;
    end else begin
      count_out        <= count;
      update_event_out <= events.upd;
    end
  end

  // ====================================
  // Read port; unmapped addresses read zero
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      case (addr_in)
        tsm_pkg::TSM_OFS_CTRL:   rdata_out <= {15'h0000, counter_enable};
        tsm_pkg::TSM_OFS_SLAVE:  rdata_out <= {1'b0, slave_cfg.ece, 7'h00,
                                               slave_cfg.src, 1'b0, slave_cfg.mode};
        tsm_pkg::TSM_OFS_ENABLE: rdata_out <= enable_reg;
        tsm_pkg::TSM_OFS_FLAGS:  rdata_out <= flags;
        tsm_pkg::TSM_OFS_COUNT:  rdata_out <= count;
        default:                 rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

endmodule : tsm_slave_timer

// >>> sim/tsm_slave_timer_checker.sv
// Checker: port-level properties of the slave-mode timer
module tsm_slave_timer_checker (
  input wire logic                 mclk_in,
  input wire logic                 rstn_in,
  input wire logic [7:0]           addr_in,
  input wire logic [15:0]          wdata_in,
  input wire logic                 wr_in,
  input wire logic                 rd_in,
  input wire logic                 filt_in1_in,
  input wire logic                 filt_in2_in,
  input wire logic                 ti1_edge_in,
  input wire logic [3:0]           itr_in,
  input wire logic                 xtrg_in,
  input wire logic [15:0]          rdata_out,
  input wire tsm_pkg::tsm_events_s dma_req_out,
  input wire logic                 irq_out,
  input wire logic [15:0]          count_out,
  input wire logic                 update_event_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // ====================================
  // Shadow registers
  logic [15:0] en_r, en_q, en_or;
  logic [2:0]  mode_r, src_r;
  logic        ece_r, cen_r, sel, sel_q;
  logic [3:0]  quiet, low_run, still_run;
  // Shadows follow bus writes exactly as the block decodes them
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_r   <= 16'h0000;
      mode_r <= 3'h0;
      src_r  <= 3'h0;
      ece_r  <= 1'b0;
      cen_r  <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == tsm_pkg::TSM_OFS_ENABLE) en_r <= wdata_in & 16'h7F5F;
      if (addr_in == tsm_pkg::TSM_OFS_SLAVE) {ece_r, src_r, mode_r} <=
          {wdata_in[14], wdata_in[6:4], wdata_in[2:0]};
      if (addr_in == tsm_pkg::TSM_OFS_CTRL) cen_r <= wdata_in[0];
    end
  end
  // Run lengths; quiet hides the settling after any write
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {en_q, sel_q} <= '0;
      {quiet, low_run, still_run} <= '0;
    end else begin
      en_q      <= en_r;
      sel_q     <= sel;
      quiet     <= wr_in ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
      low_run   <= sel ? 4'h0 : (low_run == 4'hF ? low_run : low_run + 4'h1);
      still_run <= (sel != sel_q) ? 4'h0 : (still_run == 4'hF ? still_run : still_run + 4'h1);
    end
  end
  // Selected trigger level; enables stay valid one cycle after a write clears them
  always_comb begin
    case (src_r)
      3'h4:    sel = ti1_edge_in;
      3'h5:    sel = filt_in1_in;
      3'h6:    sel = filt_in2_in;
      3'h7:    sel = xtrg_in;
      default: sel = itr_in[src_r[1:0]];
    endcase
  end
  assign en_or = en_r | en_q;
  // ====================================
  // Properties
  enable_readback_a:
    assert property ($past(rd_in && addr_in == tsm_pkg::TSM_OFS_ENABLE) |-> rdata_out == $past(en_r))
    else $error("enable read-back wrong");
  trig_dma_gate_a:
    assert property (dma_req_out.trig |-> en_or[14]) else $error("trigger dma while disabled");
  phase_dma_gate_a:
    assert property (dma_req_out.phase |-> en_or[13]) else $error("phase dma while disabled");
  chan_dma_gate_a:
    assert property ((dma_req_out.cc & ~en_or[12:9]) == 4'h0) else $error("channel dma while disabled");
  upd_dma_gate_a:
    assert property (dma_req_out.upd |-> en_or[8]) else $error("update dma while disabled");
  irq_gate_a:
    assert property (irq_out |-> (en_or & 16'h005F) != 16'h0000) else $error("irq without enable");
  internal_tick_a:
    assert property (quiet > 4'h3 && mode_r == 3'h0 && !ece_r && cen_r
        |=> count_out == $past(count_out) + 16'h0001) else $error("internal tick missed");
  gated_hold_a:
    assert property (quiet > 4'h5 && mode_r == 3'h5 && !ece_r && low_run > 4'h4
        |-> $stable(count_out)) else $error("gated counter moved while low");
  reset_clear_a:
    assert property (quiet > 4'h3 && mode_r == 3'h4 && !ece_r && sel && !sel_q
        |-> ##[1:5] count_out == 16'h0000) else $error("reset mode did not clear");
  reset_update_a:
    assert property (quiet > 4'h3 && mode_r == 3'h4 && sel && !sel_q
        |-> ##[1:4] update_event_out) else $error("reset mode gave no update");
  extclk_hold_a:
    assert property (quiet > 4'h5 && mode_r == 3'h7 && !ece_r && still_run > 4'h4
        |-> $stable(count_out)) else $error("external clock moved without edge");
  trig_event_a:
    assert property (quiet > 4'h3 && en_r[14] && sel != sel_q && (sel || mode_r == 3'h5)
        |-> ##[1:4] dma_req_out.trig) else $error("trigger event lost");
  // Main scenarios reached
  cover property (mode_r == 3'h3 && count_out != $past(count_out));
  cover property (dma_req_out.trig && mode_r == 3'h5);
  cover property (irq_out && en_r[1]);
endmodule : tsm_slave_timer_checker

// >>> sim/tsm_src_model.sv
// Partner model: encoder and trigger sources feeding the timer inputs
module tsm_src_model (
  input  wire logic  clk_in,
  output logic       in1_out,
  output logic       in2_out,
  output logic       ti1e_out,
  output logic [3:0] itr_out,
  output logic       xtrg_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quiet levels from time zero
  initial begin
    {in1_out, in2_out, ti1e_out, xtrg_out} = 4'h0;
    itr_out = 4'h0;
  end
  // One input moves per step, so no edge ever has an undefined direction
  task automatic step(input int which);
    @(posedge clk_in);
    if (which == 1) begin
      in1_out  <= ~in1_out;
      ti1e_out <= 1'b1;
    end else begin
      in2_out <= ~in2_out;
    end
    @(posedge clk_in);
    ti1e_out <= 1'b0;
  endtask : step
  // Sources 0 to 3 are internal triggers, 4 the external trigger
  task automatic set_src(input int s, input logic v);
    @(posedge clk_in);
    if (s < 4) begin
      itr_out[s] <= v;
    end else begin
      xtrg_out <= v;
    end
  endtask : set_src
endmodule : tsm_src_model

// >>> sim/tb.sv
// Testbench: slave-mode timer against a behavioural model
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 mclk_in = 1'b0;
  logic                 rstn_in = 1'b0;
  logic [7:0]           addr = 8'h00;
  logic [15:0]          wdata = 16'h0000;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic [3:0]           cc_ev = 4'h0;
  logic                 ph_ev = 1'b0;
  logic                 in1, in2, ti1e, xtrg, irq, upd;
  logic [3:0]           itr;
  logic [15:0]          rdata, cnt;
  tsm_pkg::tsm_events_s dma;
  logic [6:0]           seen = 7'h00;
  logic                 zseen = 1'b0;
  logic                 useen = 1'b0;
  int                   miscompares = 0;
  int                   checks_done = 0;
  int                   cyc = 0;
  always #2 mclk_in = ~mclk_in;
  tsm_slave_timer dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .filt_in1_in(in1), .filt_in2_in(in2), .ti1_edge_in(ti1e),
    .itr_in(itr), .xtrg_in(xtrg), .cc_event_in(cc_ev), .phase_event_in(ph_ev),
    .rdata_out(rdata), .dma_req_out(dma), .irq_out(irq), .count_out(cnt),
    .update_event_out(upd));
  tsm_src_model src_u (.clk_in(mclk_in), .in1_out(in1), .in2_out(in2), .ti1e_out(ti1e),
    .itr_out(itr), .xtrg_out(xtrg));
  // Sticky monitors of pulses, plus the hang guard
  always @(posedge mclk_in) begin
    seen  <= seen | dma;
    zseen <= zseen | (cnt == 16'h0000);
    useen <= useen | upd;
    cyc++;
    if (cyc > 5000) begin
      miscompares++;
      complete_run();
    end
  end
  // ====================================
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    {rd, addr} <= {1'b1, a};
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Source is changed only with the slave mode at zero
  task automatic set_mode(input logic [2:0] src, input logic [2:0] m, input logic e);
    wr_reg(tsm_pkg::TSM_OFS_SLAVE, {1'b0, e, 7'h00, src, 1'b0, 3'h0});
    wr_reg(tsm_pkg::TSM_OFS_SLAVE, {1'b0, e, 7'h00, src, 1'b0, m});
  endtask : set_mode
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // ====================================
  // Main sequence
  initial begin
    logic [15:0] v, c0;
    int          model, k, w;
    void'($urandom(23616));
    repeat (4) @(posedge mclk_in);
    rstn_in <= 1'b1;
    tick(3);
    rd_reg(tsm_pkg::TSM_OFS_ENABLE, v);
    chk("enable reset", v, 16'h0000);
    rd_reg(tsm_pkg::TSM_OFS_SLAVE, v);
    chk("slave reset", v, 16'h0000);
    c0 = 16'($urandom);
    wr_reg(tsm_pkg::TSM_OFS_ENABLE, c0);
    rd_reg(tsm_pkg::TSM_OFS_ENABLE, v);
    chk("enable rw", v, c0 & 16'h7F5F);
    wr_reg(8'h04, 16'hFFFF);
    rd_reg(8'h04, v);
    chk("unmapped", v, 16'h0000);
    $display("test registers done");
    // Each channel and phase event with its enables off, then on
    for (int i = 0; i < 5; i++) begin
      for (int e = 0; e < 2; e++) begin
        w = (i < 4) ? 9 + i : 13;
        k = (i < 4) ? 1 + i : 5;
        wr_reg(tsm_pkg::TSM_OFS_ENABLE, (e != 0) ? 16'(1 << w) | 16'(1 << (i + 1)) : 16'h0000);
        seen = 7'h00;
        @(posedge mclk_in);
        cc_ev <= (i < 4) ? 4'(1 << i) : 4'h0;
        ph_ev <= (i == 4);
        @(posedge mclk_in);
        {cc_ev, ph_ev} <= 5'h00;
        tick(4);
        chk("event dma", 16'(seen[k]), 16'(e));
        chk("event irq", 16'(irq), 16'(e != 0 && i < 4));
        wr_reg(tsm_pkg::TSM_OFS_FLAGS, 16'h0000);
        tick(3);
        chk("irq cleared", 16'(irq), 16'h0000);
      end
    end
    $display("test events done");
    wr_reg(tsm_pkg::TSM_OFS_CTRL, 16'h0001);
    tick(3);
    c0 = cnt;
    tick(50);
    chk("internal count", cnt, c0 + 16'h0032);
    // Encoder modes against a direction model
    for (int m = 1; m < 4; m++) begin
      set_mode(3'h0, 3'(m), 1'b0);
      wr_reg(tsm_pkg::TSM_OFS_COUNT, 16'h8000);
      model = 32768;
      repeat (12) begin
        w = $urandom_range(1, 2);
        src_u.step(w);
        tick(3);
        if (w == 1 && m != 1) model += (in1 != in2) ? 1 : -1;
        if (w == 2 && m != 2) model += (in2 == in1) ? 1 : -1;
        chk("encoder count", cnt, 16'(model));
      end
    end
    $display("test encoder done");
    wr_reg(tsm_pkg::TSM_OFS_ENABLE, 16'h4141);
    set_mode(3'h0, 3'h4, 1'b0);
    tick(20);
    {seen, zseen, useen} = 9'h000;
    src_u.set_src(0, 1'b1);
    tick(5);
    chk("reset zero", 16'(zseen), 16'h0001);
    chk("reset update", 16'(useen), 16'h0001);
    chk("dma trig upd", 16'(seen), 16'h0041);
    chk("irq on", 16'(irq), 16'h0001);
    src_u.set_src(0, 1'b0);
    wr_reg(tsm_pkg::TSM_OFS_FLAGS, 16'h0000);
    set_mode(3'h1, 3'h5, 1'b0);
    tick(4);
    c0 = cnt;
    tick(10);
    chk("gated hold", cnt, c0);
    src_u.set_src(1, 1'b1);
    repeat (19) @(posedge mclk_in);
    src_u.set_src(1, 1'b0);
    tick(5);
    chk("gated run", cnt, c0 + 16'h0014);
    wr_reg(tsm_pkg::TSM_OFS_CTRL, 16'h0000);
    set_mode(3'h2, 3'h6, 1'b0);
    tick(3);
    c0 = cnt;
    tick(5);
    chk("trigger hold", cnt, c0);
    src_u.set_src(2, 1'b1);
    src_u.set_src(2, 1'b0);
    tick(4);
    c0 = cnt;
    tick(10);
    chk("trigger run", cnt, c0 + 16'h000A);
    rd_reg(tsm_pkg::TSM_OFS_CTRL, v);
    chk("trigger enable", v & 16'h0001, 16'h0001);
    $display("test trigger modes done");
    // External clock from the selected trigger, then from the external trigger
    for (int e = 0; e < 2; e++) begin
      set_mode(3'h3, 3'h7, 1'(e));
      tick(3);
      c0 = cnt;
      k = $urandom_range(3, 8);
      repeat (k) begin
        src_u.set_src(3 + e, 1'b1);
        src_u.set_src(3 + e, 1'b0);
      end
      tick(4);
      chk("external clock", cnt, c0 + 16'(k));
    end
    $display("test external clock done");
    complete_run();
  end
endmodule : tb
bind tsm_slave_timer tsm_slave_timer_checker chk_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .filt_in1_in(filt_in1_in), .filt_in2_in(filt_in2_in), .ti1_edge_in(ti1_edge_in),
  .itr_in(itr_in), .xtrg_in(xtrg_in), .rdata_out(rdata_out), .dma_req_out(dma_req_out),
  .irq_out(irq_out), .count_out(count_out), .update_event_out(update_event_out));
